// file: logic/jspu_map.vh
`ifndef JSPU_MAP_VH
`define JSPU_MAP_VH
// message and signal counts
`define JSPU_NUM_TX        11
`define JSPU_NUM_RX        9
`define JSPU_SIG_PER_MSG   4
`define JSPU_SIG_W         32
// control source codes
`define JSPU_SRC_NOT_USED  5'h00
`define JSPU_SRC_RX_MSG    5'h01
`define JSPU_SRC_RX_TOUT   5'h10
`define JSPU_SRC_MAX       5'h11
// frame header defaults
`define JSPU_PRIO_RESET    3'h6
`define JSPU_ADDR_GLOBAL   8'hff
`define JSPU_PGN_DEFAULT   18'h0ff00
// timing
`define JSPU_CLK_HZ        40000000
`define JSPU_STARTUP_SEC   5
`define JSPU_STARTUP_CYC   (`JSPU_STARTUP_SEC * `JSPU_CLK_HZ)
`define JSPU_MS_CYC        (`JSPU_CLK_HZ / 1000)
`endif

// file: logic/jspu_skid.v
`timescale 1ns/100ps
// two-entry buffer so a stalled receiver loses no frame
module jspu_skid #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         reset,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // jspu_skid

// file: logic/jspu_top.v
`timescale 1ns/100ps
`include "jspu_map.vh"
module jspu_top #(
  parameter STARTUP_CYC = `JSPU_STARTUP_CYC,
  parameter MS_CYC      = `JSPU_MS_CYC
) (
  input  wire         ref_clk,
  input  wire         reset,
  // transmit slot configuration, one slot at a time
  input  wire         tx_cfg_we,
  input  wire [3:0]   tx_cfg_slot,
  input  wire         tx_cfg_if,
  input  wire [17:0]  tx_cfg_pgn,
  input  wire [15:0]  tx_cfg_rate_ms,
  input  wire [2:0]   tx_cfg_prio,
  input  wire [7:0]   tx_cfg_dest,
  // transmit signal configuration
  input  wire         sig_cfg_we,
  input  wire [3:0]   sig_cfg_slot,
  input  wire [1:0]   sig_cfg_idx,
  input  wire [4:0]   sig_cfg_src,
  input  wire [7:0]   sig_cfg_num,
  input  wire [5:0]   sig_cfg_size,
  input  wire [2:0]   sig_cfg_byte,
  input  wire [2:0]   sig_cfg_bit,
  input  wire [31:0]  sig_cfg_offset,
  input  wire [15:0]  sig_cfg_res,
  // live source value request: src code and number out, value back in
  output reg  [4:0]   src_sel_type_r,
  output reg  [7:0]   src_sel_num_r,
  input  wire [31:0]  src_value,
  // outgoing frame
  output wire         txf_valid,
  input  wire         txf_ready,
  output wire         txf_if,
  output wire [2:0]   txf_prio,
  output wire [17:0]  txf_pgn,
  output wire [7:0]   txf_dest,
  output wire [63:0]  txf_data,
  // receive slot configuration
  input  wire         rx_cfg_we,
  input  wire [3:0]   rx_cfg_slot,
  input  wire         rx_cfg_en,
  input  wire         rx_cfg_if,
  input  wire [17:0]  rx_cfg_pgn,
  input  wire [7:0]   rx_cfg_sa,
  input  wire [15:0]  rx_cfg_tout_ms,
  input  wire [5:0]   rx_cfg_size,
  input  wire [2:0]   rx_cfg_byte,
  input  wire [2:0]   rx_cfg_bit,
  input  wire [15:0]  rx_cfg_res,
  input  wire [31:0]  rx_cfg_offset,
  input  wire [31:0]  rx_cfg_min,
  input  wire [31:0]  rx_cfg_max,
  // incoming frame
  input  wire         rxf_valid,
  input  wire         rxf_if,
  input  wire [17:0]  rxf_pgn,
  input  wire [7:0]   rxf_sa,
  input  wire [63:0]  rxf_data,
  // receive results
  output wire [287:0] rx_value_r,
  output wire [8:0]   rx_digital_r,
  output wire [8:0]   rx_lost_r,
  output reg          startup_done_r
);
  localparam NT = `JSPU_NUM_TX;
  localparam NR = `JSPU_NUM_RX;
  localparam NS = NT * 4;
  // transmit states, one-hot
  localparam T_IDLE = 4'h1;
  localparam T_SIG  = 4'h2;
  localparam T_PUSH = 4'h4;
  localparam T_WAIT = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // transmit configuration
  reg         txc_if   [0:NT-1];
  reg  [17:0] txc_pgn  [0:NT-1];
  reg  [15:0] txc_rate [0:NT-1];
  reg  [2:0]  txc_prio [0:NT-1];
  reg  [7:0]  txc_dest [0:NT-1];
  reg  [15:0] txc_cnt  [0:NT-1];
  reg  [4:0]  sc_src   [0:NS-1];
  reg  [7:0]  sc_num   [0:NS-1];
  reg  [5:0]  sc_size  [0:NS-1];
  reg  [2:0]  sc_byte  [0:NS-1];
  reg  [2:0]  sc_bit   [0:NS-1];
  reg  [31:0] sc_off   [0:NS-1];
  reg  [15:0] sc_res   [0:NS-1];
  integer     i;
  integer     j;
  integer     k;
  wire [5:0]  sig_wa;

  assign sig_wa = sig_cfg_slot * 3'h4 + {4'h0, sig_cfg_idx};

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < NT; i = i + 1) begin
        txc_if[i]   <= 1'b0;
        txc_pgn[i]  <= `JSPU_PGN_DEFAULT;
        txc_rate[i] <= 16'h0000;
        txc_prio[i] <= `JSPU_PRIO_RESET;
        txc_dest[i] <= `JSPU_ADDR_GLOBAL;
      end
      for (i = 0; i < NS; i = i + 1) begin
        sc_src[i]  <= `JSPU_SRC_NOT_USED;
        sc_num[i]  <= 8'h00;
        sc_size[i] <= 6'h00;
        sc_byte[i] <= 3'h0;
        sc_bit[i]  <= 3'h0;
        sc_off[i]  <= 32'h0;
        sc_res[i]  <= 16'h0001;
      end
    end else begin
      if (tx_cfg_we && tx_cfg_slot < NT) begin
        txc_if[tx_cfg_slot]   <= tx_cfg_if;
        txc_pgn[tx_cfg_slot]  <= tx_cfg_pgn;
        txc_rate[tx_cfg_slot] <= tx_cfg_rate_ms;
        txc_prio[tx_cfg_slot] <= tx_cfg_prio;
        txc_dest[tx_cfg_slot] <= tx_cfg_dest;
      end
      if (sig_cfg_we && sig_cfg_slot < NT) begin
        // reception-timeout source is refused for transmit signals
        sc_src[sig_wa]  <= (sig_cfg_src == `JSPU_SRC_RX_TOUT ||
                            sig_cfg_src > `JSPU_SRC_MAX) ?
                           `JSPU_SRC_NOT_USED : sig_cfg_src;
        sc_num[sig_wa]  <= sig_cfg_num;
        sc_size[sig_wa] <= sig_cfg_size;
        sc_byte[sig_wa] <= sig_cfg_byte;
        sc_bit[sig_wa]  <= sig_cfg_bit;
        sc_off[sig_wa]  <= sig_cfg_offset;
        sc_res[sig_wa]  <= sig_cfg_res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start-up hold-off and millisecond tick
  reg [31:0] st_cnt_r;
  reg [15:0] ms_cnt_r;
  reg        ms_tick_r;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_cnt_r       <= 32'h0;
      startup_done_r <= 1'b0;
      ms_cnt_r       <= 16'h0;
      ms_tick_r      <= 1'b0;
    end else begin
      if (!startup_done_r) begin
        st_cnt_r <= st_cnt_r + 32'h1;
        if (st_cnt_r == STARTUP_CYC - 1) begin
          startup_done_r <= 1'b1;
        end
      end
      ms_tick_r <= (ms_cnt_r == MS_CYC - 1);
      ms_cnt_r  <= (ms_cnt_r == MS_CYC - 1) ? 16'h0 : ms_cnt_r + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-slot due flags; a slot that shares a PGN with a lower one
  // is carried in that lower slot's bundle instead
  wire [NT-1:0] leader;
  wire [NT-1:0] bundled;
  reg  [NT-1:0] due_r;
  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_lead
      wire [NT-1:0] lower_same;
      wire [NT-1:0] any_same;
      genvar h;
      for (h = 0; h < NT; h = h + 1) begin : g_cmp
        assign lower_same[h] = (h < g) && (txc_pgn[h] == txc_pgn[g]);
        assign any_same[h]   = (h != g) && (txc_pgn[h] == txc_pgn[g]);
      end
      assign leader[g]  = ~|lower_same;
      assign bundled[g] = |any_same;
    end
  endgenerate

  reg [3:0] t_state_r;
  reg [3:0] t_slot_r;
  reg [5:0] t_sig_r;
  reg [1:0] t_phase_r;
  reg [63:0] t_data_r;
  reg [63:0] t_data_nxt;
  reg [31:0] t_scaled;
  reg [47:0] t_prod;
  reg [63:0] t_mask;
  reg [5:0]  t_pos;
  wire       t_member;
  wire       txf_in_ready;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      due_r <= {NT{1'b0}};
      for (j = 0; j < NT; j = j + 1) begin
        txc_cnt[j] <= 16'h0;
      end
    end else begin
      // clear first: a new due in the same cycle overrides it
      if (t_state_r == T_WAIT && txf_in_ready) begin
        due_r[t_slot_r] <= 1'b0;
      end
      for (j = 0; j < NT; j = j + 1) begin
        if (!startup_done_r) begin
          txc_cnt[j] <= 16'h0;
        end else if (ms_tick_r && leader[j] && txc_rate[j] != 16'h0) begin
          if (txc_cnt[j] + 16'h1 >= txc_rate[j]) begin
            txc_cnt[j] <= 16'h0;
            due_r[j]   <= 1'b1;
          end else begin
            txc_cnt[j] <= txc_cnt[j] + 16'h1;
          end
        end
      end
    end
  end

  // signal belongs to the current bundle
  assign t_member = (t_sig_r[5:2] == t_slot_r) ||
                    (txc_pgn[t_sig_r[5:2]] == txc_pgn[t_slot_r]);

  // scale and place one signal: offset first, then resolution
  always @* begin
    t_prod     = (src_value - sc_off[t_sig_r]) * sc_res[t_sig_r];
    t_scaled   = t_prod[31:0];
    if (sc_size[t_sig_r] < 6'h20 &&
        (t_prod >> sc_size[t_sig_r]) != 48'h0) begin
      t_scaled = ~(32'hffffffff << sc_size[t_sig_r]);
    end
    t_pos      = {sc_byte[t_sig_r], sc_bit[t_sig_r]};
    t_mask     = (sc_size[t_sig_r] >= 6'h20) ? 64'hffffffff :
                 ~(64'hffffffffffffffff << sc_size[t_sig_r]);
    t_data_nxt = t_data_r;
    if (sc_src[t_sig_r] != `JSPU_SRC_NOT_USED && t_member) begin
      t_data_nxt = (t_data_r & ~(t_mask << t_pos)) |
                   (({32'h0, t_scaled} & t_mask) << t_pos);
    end
  end

  reg txf_in_valid_r;
  reg  [2:0]  f_prio_r;
  reg  [17:0] f_pgn_r;
  reg  [7:0]  f_dest_r;
  reg         f_if_r;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      t_state_r      <= T_IDLE;
      t_slot_r       <= 4'h0;
      t_sig_r        <= 6'h0;
      t_phase_r      <= 2'h0;
      t_data_r       <= 64'hffffffffffffffff;
      src_sel_type_r <= `JSPU_SRC_NOT_USED;
      src_sel_num_r  <= 8'h00;
      txf_in_valid_r <= 1'b0;
      f_prio_r       <= `JSPU_PRIO_RESET;
      f_pgn_r        <= `JSPU_PGN_DEFAULT;
      f_dest_r       <= `JSPU_ADDR_GLOBAL;
      f_if_r         <= 1'b0;
    end else begin
      case (t_state_r)
        T_IDLE: begin
          for (k = NT - 1; k >= 0; k = k - 1) begin
            if (due_r[k] && (bundled[k] || txc_rate[k] != 16'h0)) begin
              t_slot_r <= k[3:0];
            end
          end
          if (|due_r) begin
            t_state_r <= T_SIG;
            t_sig_r   <= 6'h0;
            t_phase_r <= 2'h0;
            t_data_r  <= 64'hffffffffffffffff;
          end
        end
        T_SIG: begin
          // phase 0 selects the source, phase 2 samples it
          if (t_phase_r == 2'h0) begin
            src_sel_type_r <= sc_src[t_sig_r];
            src_sel_num_r  <= sc_num[t_sig_r];
            t_phase_r      <= 2'h1;
          end else if (t_phase_r == 2'h1) begin
            t_phase_r <= 2'h2;
          end else begin
            t_data_r  <= t_data_nxt;
            t_phase_r <= 2'h0;
            if (t_sig_r == NS - 1) begin
              t_state_r <= T_PUSH;
            end else begin
              t_sig_r <= t_sig_r + 6'h1;
            end
          end
        end
        T_PUSH: begin
          f_if_r         <= txc_if[t_slot_r];
          f_prio_r       <= txc_prio[t_slot_r];
          f_pgn_r        <= txc_pgn[t_slot_r];
          // pdu1 when pf below 0xf0, else destination is not used
          f_dest_r       <= (txc_pgn[t_slot_r][15:12] != 4'hf) ?
                            txc_dest[t_slot_r] : `JSPU_ADDR_GLOBAL;
          txf_in_valid_r <= 1'b1;
          t_state_r      <= T_WAIT;
        end
        T_WAIT: begin
          if (txf_in_ready) begin
            txf_in_valid_r <= 1'b0;
            t_state_r      <= T_IDLE;
          end
        end
        default: t_state_r <= T_IDLE;
      endcase
    end
  end

  jspu_skid #(.W(94)) u_skid (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (txf_in_valid_r),
    .in_ready  (txf_in_ready),
    .in_data   ({f_if_r, f_prio_r, f_pgn_r, f_dest_r, t_data_r}),
    .out_valid (txf_valid),
    .out_ready (txf_ready),
    .out_data  ({txf_if, txf_prio, txf_pgn, txf_dest, txf_data})
  );

  ////////////////////////////////////////////////////////////////////////
  // receive slots
  generate
    for (g = 0; g < NR; g = g + 1) begin : g_rx
      reg         en_r;
      reg         if_r;
      reg  [17:0] pgn_r;
      reg  [7:0]  sa_r;
      reg  [15:0] tout_r;
      reg  [15:0] age_r;
      reg  [5:0]  size_r;
      reg  [5:0]  pos_r;
      reg  [15:0] res_r;
      reg  [31:0] off_r;
      reg  [31:0] min_r;
      reg  [31:0] max_r;
      wire        pdu1;
      wire        hit;
      wire [63:0] raw;
      wire [31:0] field;
      wire [47:0] prod;
      wire [31:0] val;
      reg  [31:0] val_r;
      reg         dig_r;
      reg         lost_r;

      assign rx_value_r[g*32 +: 32] = val_r;
      assign rx_digital_r[g]        = dig_r;
      assign rx_lost_r[g]           = lost_r;
      assign pdu1  = (pgn_r[15:12] != 4'hf);
      assign hit   = rxf_valid && en_r && (rxf_if == if_r) &&
                     (rxf_pgn == pgn_r) &&
                     (!pdu1 || sa_r == `JSPU_ADDR_GLOBAL ||
                      rxf_sa == sa_r);
      assign raw   = rxf_data >> pos_r;
      assign field = (size_r >= 6'h20) ? raw[31:0] :
                     raw[31:0] & ~(32'hffffffff << size_r);
      assign prod  = field * res_r;
      assign val   = prod[31:0] + off_r;

      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          en_r   <= 1'b0;
          if_r   <= 1'b0;
          pgn_r  <= `JSPU_PGN_DEFAULT;
          sa_r   <= `JSPU_ADDR_GLOBAL;
          tout_r <= 16'h0;
          age_r  <= 16'h0;
          size_r <= 6'h08;
          pos_r  <= 6'h00;
          res_r  <= 16'h0001;
          off_r  <= 32'h0;
          min_r  <= 32'h0;
          max_r  <= 32'h0;
          val_r  <= 32'h0;
          dig_r  <= 1'b0;
          lost_r <= 1'b0;
        end else begin
          if (rx_cfg_we && rx_cfg_slot == g) begin
            en_r   <= rx_cfg_en;
            if_r   <= rx_cfg_if;
            pgn_r  <= rx_cfg_pgn;
            sa_r   <= rx_cfg_sa;
            tout_r <= rx_cfg_tout_ms;
            size_r <= rx_cfg_size;
            pos_r  <= {rx_cfg_byte, rx_cfg_bit};
            res_r  <= rx_cfg_res;
            off_r  <= rx_cfg_offset;
            min_r  <= rx_cfg_min;
            max_r  <= rx_cfg_max;
          end
          if (hit) begin
            age_r  <= 16'h0;
            lost_r <= 1'b0;
            // output clamped to the configured range
            val_r <= ($signed(val) < $signed(min_r)) ? min_r :
                     ($signed(val) > $signed(max_r)) ? max_r : val;
            if ($signed(val) <= $signed(min_r)) begin
              dig_r <= 1'b0;
            end else if ($signed(val) >= $signed(max_r)) begin
              dig_r <= 1'b1;
            end
          end else if (!en_r || tout_r == 16'h0) begin
            age_r  <= 16'h0;
            lost_r <= 1'b0;
          end else if (ms_tick_r) begin
            if (age_r + 16'h1 >= tout_r) begin
              lost_r <= 1'b1;
            end else begin
              age_r <= age_r + 16'h1;
            end
          end
        end
      end
    end
  endgenerate
endmodule // jspu_top

// file: dv/jspu_top_checker.sv
`timescale 1ns/100ps
module jspu_top_checker #(
  parameter STARTUP_CYC = 100,
  parameter MS_CYC      = 100
) (
  input wire         ref_clk,
  input wire         reset,
  input wire         txf_valid,
  input wire         txf_ready,
  input wire         txf_if,
  input wire [2:0]   txf_prio,
  input wire [17:0]  txf_pgn,
  input wire [7:0]   txf_dest,
  input wire [63:0]  txf_data,
  input wire         rxf_valid,
  input wire         rx_cfg_we,
  input wire [3:0]   rx_cfg_slot,
  input wire [31:0]  rx_cfg_min,
  input wire [31:0]  rx_cfg_max,
  input wire [287:0] rx_value_r,
  input wire [8:0]   rx_digital_r,
  input wire [8:0]   rx_lost_r,
  input wire         startup_done_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////
  // saturating age counter; only the start-up window needs it
  reg [31:0] cnt_r;
  reg        seen_r;
  reg [31:0] min0_r;
  reg [31:0] max0_r;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r  <= 32'h0;
      seen_r <= 1'b0;
      min0_r <= 32'h0;
      max0_r <= 32'h0;
    end else begin
      if (cnt_r < STARTUP_CYC + 8)
        cnt_r <= cnt_r + 32'h1;
      if (rx_cfg_we)
        seen_r <= 1'b1;
      if (rx_cfg_we && rx_cfg_slot == 4'h0) begin
        min0_r <= rx_cfg_min;
        max0_r <= rx_cfg_max;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_tx_startup_hold: assert property (!startup_done_r |-> !txf_valid)
    else $error("frame offered before start-up delay");
  a_startup_early: assert property (startup_done_r |-> cnt_r >= STARTUP_CYC - 2)
    else $error("start-up delay ended early");
  a_startup_late: assert property (cnt_r >= STARTUP_CYC + 4 |-> startup_done_r)
    else $error("start-up delay ended late");
  a_startup_stays: assert property (startup_done_r |=> startup_done_r)
    else $error("start-up flag dropped");
  a_frame_held: assert property (txf_valid && !txf_ready |=> txf_valid &&
    $stable({txf_if, txf_prio, txf_pgn, txf_dest, txf_data}))
    else $error("stalled frame changed");
  a_pdu2_global: assert property (txf_valid && txf_pgn[15:12] == 4'hf
    |-> txf_dest == 8'hff)
    else $error("broadcast frame carries a destination");
  a_rx_clean: assert property (!seen_r |-> rx_lost_r == 9'h0 &&
    rx_digital_r == 9'h0 && rx_value_r == 288'h0)
    else $error("receive result before any slot enabled");
  a_dig_on_max: assert property ($rose(rx_digital_r[0])
    |-> $signed(rx_value_r[31:0]) >= $signed(max0_r))
    else $error("digital on below maximum");
  a_dig_off_min: assert property ($fell(rx_digital_r[0])
    |-> $signed(rx_value_r[31:0]) <= $signed(min0_r))
    else $error("digital off above minimum");
  a_rx_value_cause: assert property (!$past(rxf_valid) && !$past(rxf_valid, 2)
    && !$past(rx_cfg_we) |-> $stable(rx_value_r))
    else $error("receive value moved without a frame");
  c_stall: cover property (txf_valid && !txf_ready);
  c_dig_on: cover property ($rose(rx_digital_r[0]));
  c_lost: cover property ($rose(rx_lost_r[0]));
endmodule // jspu_top_checker

bind jspu_top jspu_top_checker #(.STARTUP_CYC(STARTUP_CYC), .MS_CYC(MS_CYC))
  i_jspu_top_checker (.ref_clk, .reset, .txf_valid, .txf_ready, .txf_if,
  .txf_prio, .txf_pgn, .txf_dest, .txf_data, .rxf_valid, .rx_cfg_we,
  .rx_cfg_slot, .rx_cfg_min, .rx_cfg_max, .rx_value_r, .rx_digital_r,
  .rx_lost_r, .startup_done_r);

// file: dv/jspu_can_net.sv
`timescale 1ns/100ps
// network side: sinks frames with random stalls, sources received frames
module jspu_can_net (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        txf_valid,
  output reg         txf_ready,
  output reg         rxf_valid,
  output reg         rxf_if,
  output reg  [17:0] rxf_pgn,
  output reg  [7:0]  rxf_sa,
  output reg  [63:0] rxf_data
);
  integer    seed = 32'h723d;
  reg        go   = 1'b0;
  reg        q_if;
  reg [17:0] q_pgn;
  reg [7:0]  q_sa;
  reg [63:0] q_data;
  initial begin
    {txf_ready, rxf_valid, rxf_if, rxf_pgn, rxf_sa, rxf_data} = '0;
  end
  always @(negedge ref_clk) begin
    txf_ready <= ($random(seed) & 3) != 0;
    if (go) begin
      rxf_valid <= 1'b1;
      rxf_if    <= q_if;
      rxf_pgn   <= q_pgn;
      rxf_sa    <= q_sa;
      rxf_data  <= q_data;
      go        <= 1'b0;
    end else begin
      // idle bus inverts every field each cycle, so the last frame reappears every other cycle with valid low
      rxf_valid <= 1'b0;
      rxf_if    <= ~rxf_if;
      rxf_pgn   <= ~rxf_pgn;
      rxf_sa    <= ~rxf_sa;
      rxf_data  <= ~rxf_data;
    end
  end
  task send(input i, input [17:0] p, input [7:0] s, input [63:0] d);
    @(posedge ref_clk);
    {q_if, q_pgn, q_sa, q_data} = {i, p, s, d};
    go = 1'b1;
    @(posedge ref_clk);
  endtask
endmodule // jspu_can_net

// file: dv/jspu_top_test.sv
`timescale 1ns/100ps
`include "jspu_map.vh"
module jspu_top_test;
  reg ref_clk = 1'b0;
  reg reset   = 1'b1;
  reg         tx_cfg_we, tx_cfg_if, sig_cfg_we, rx_cfg_we, rx_cfg_en, rx_cfg_if;
  reg [3:0]   tx_cfg_slot, sig_cfg_slot, rx_cfg_slot;
  reg [17:0]  tx_cfg_pgn, rx_cfg_pgn;
  reg [15:0]  tx_cfg_rate_ms, sig_cfg_res, rx_cfg_tout_ms, rx_cfg_res;
  reg [2:0]   tx_cfg_prio, sig_cfg_byte, sig_cfg_bit, rx_cfg_byte, rx_cfg_bit;
  reg [7:0]   tx_cfg_dest, sig_cfg_num, rx_cfg_sa;
  reg [1:0]   sig_cfg_idx;
  reg [4:0]   sig_cfg_src;
  reg [5:0]   sig_cfg_size, rx_cfg_size;
  reg [31:0]  sig_cfg_offset, rx_cfg_offset, rx_cfg_min, rx_cfg_max;
  wire        txf_valid, txf_ready, txf_if, rxf_valid, rxf_if, startup_done_r;
  wire [2:0]  txf_prio;
  wire [17:0] txf_pgn, rxf_pgn;
  wire [7:0]  txf_dest, rxf_sa, src_sel_num_r;
  wire [63:0] txf_data, rxf_data;
  wire [4:0]  src_sel_type_r;
  wire [31:0] src_value;
  wire [287:0] rx_value_r;
  wire [8:0]  rx_digital_r, rx_lost_r;
  integer     n_errors = 0;
  integer     n_checks = 0;
  integer     seed     = 32'h723d;
  logic [93:0] tq[$];
  logic [32:0] rq[$];
  reg         rx_d1 = 1'b0;
  reg         rx_d2 = 1'b0;
  // each source answers with a value unique to its type and number for numbers below 100
  assign src_value = src_sel_type_r * 32'h64 + src_sel_num_r;
  always #12.5 ref_clk = ~ref_clk;
  jspu_top #(.STARTUP_CYC(100), .MS_CYC(100)) i_jspu_top (
    .ref_clk, .reset, .tx_cfg_we, .tx_cfg_slot, .tx_cfg_if, .tx_cfg_pgn,
    .tx_cfg_rate_ms, .tx_cfg_prio, .tx_cfg_dest, .sig_cfg_we, .sig_cfg_slot,
    .sig_cfg_idx, .sig_cfg_src, .sig_cfg_num, .sig_cfg_size, .sig_cfg_byte,
    .sig_cfg_bit, .sig_cfg_offset, .sig_cfg_res, .src_sel_type_r,
    .src_sel_num_r, .src_value, .txf_valid, .txf_ready, .txf_if, .txf_prio,
    .txf_pgn, .txf_dest, .txf_data, .rx_cfg_we, .rx_cfg_slot, .rx_cfg_en,
    .rx_cfg_if, .rx_cfg_pgn, .rx_cfg_sa, .rx_cfg_tout_ms, .rx_cfg_size,
    .rx_cfg_byte, .rx_cfg_bit, .rx_cfg_res, .rx_cfg_offset, .rx_cfg_min,
    .rx_cfg_max, .rxf_valid, .rxf_if, .rxf_pgn, .rxf_sa, .rxf_data,
    .rx_value_r, .rx_digital_r, .rx_lost_r, .startup_done_r);
  jspu_can_net i_jspu_can_net (.ref_clk, .reset, .txf_valid, .txf_ready,
    .rxf_valid, .rxf_if, .rxf_pgn, .rxf_sa, .rxf_data);
  ////////////////////////////////////////////////////////////////////////////
  task check(input string name, input [93:0] exp, input [93:0] got);
    n_checks = n_checks + 1;
    if (exp !== got) begin
      n_errors = n_errors + 1;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task stop_test;
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cfg_tx(input [3:0] s, input i, input [17:0] p, input [15:0] r,
              input [2:0] pr, input [7:0] d);
    @(negedge ref_clk);
    {tx_cfg_we, tx_cfg_slot, tx_cfg_if, tx_cfg_pgn} <= {1'b1, s, i, p};
    {tx_cfg_rate_ms, tx_cfg_prio, tx_cfg_dest} <= {r, pr, d};
    @(negedge ref_clk);
    tx_cfg_we <= 1'b0;
  endtask
  task cfg_sig(input [3:0] s, input [1:0] x, input [4:0] src, input [7:0] n,
               input [5:0] sz, input [2:0] by, input [2:0] bi,
               input [31:0] o, input [15:0] r);
    @(negedge ref_clk);
    {sig_cfg_we, sig_cfg_slot, sig_cfg_idx, sig_cfg_src} <= {1'b1, s, x, src};
    {sig_cfg_num, sig_cfg_size, sig_cfg_byte, sig_cfg_bit} <= {n, sz, by, bi};
    {sig_cfg_offset, sig_cfg_res} <= {o, r};
    @(negedge ref_clk);
    sig_cfg_we <= 1'b0;
  endtask
  task cfg_rx(input [3:0] s, input i, input [17:0] p, input [7:0] sa,
              input [15:0] t, input [5:0] sz, input [2:0] by,
              input [15:0] r, input [31:0] o, input [31:0] mn, input [31:0] mx);
    @(negedge ref_clk);
    {rx_cfg_we, rx_cfg_slot, rx_cfg_en, rx_cfg_if} <= {1'b1, s, 1'b1, i};
    {rx_cfg_pgn, rx_cfg_sa, rx_cfg_tout_ms, rx_cfg_size} <= {p, sa, t, sz};
    {rx_cfg_byte, rx_cfg_bit, rx_cfg_res, rx_cfg_offset} <= {by, 3'h0, r, o};
    {rx_cfg_min, rx_cfg_max} <= {mn, mx};
    @(negedge ref_clk);
    rx_cfg_we <= 1'b0;
  endtask
  task wait_tx;
    integer k;
    for (k = 0; k < 3000 && tq.size() > 0; k = k + 1)
      @(negedge ref_clk);
    check("tx_count", 0, tq.size());
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (txf_valid === 1'b1 && txf_ready === 1'b1) begin
      if (tq.size() == 0)
        check("tx_unexpected", 0, 1);
      else
        check("tx_frame", tq.pop_front(), {txf_if, txf_prio, txf_pgn,
          txf_dest, txf_data});
    end
  end
  always @(negedge ref_clk) begin
    if (rx_d2 && rq.size() > 0)
      check("rx_slot0", rq.pop_front(), {rx_digital_r[0], rx_value_r[31:0]});
    rx_d2 <= rx_d1;
    rx_d1 <= rxf_valid;
  end
  initial begin
    #(25 * 20000);
    n_errors = n_errors + 1;
    stop_test;
  end
  initial begin : main
    integer k, s, f;
    reg [63:0] d;
    reg [31:0] v;
    reg dig, i;
    reg [7:0] sa;
    {tx_cfg_we, tx_cfg_if, sig_cfg_we, rx_cfg_we, rx_cfg_en, rx_cfg_if,
     tx_cfg_slot, sig_cfg_slot, rx_cfg_slot, tx_cfg_pgn, rx_cfg_pgn,
     tx_cfg_rate_ms, sig_cfg_res, rx_cfg_tout_ms, rx_cfg_res, tx_cfg_prio,
     sig_cfg_byte, sig_cfg_bit, rx_cfg_byte, rx_cfg_bit, tx_cfg_dest,
     sig_cfg_num, rx_cfg_sa, sig_cfg_idx, sig_cfg_src, sig_cfg_size,
     rx_cfg_size, sig_cfg_offset, rx_cfg_offset, rx_cfg_min, rx_cfg_max} = '0;
    repeat (8) @(negedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check("startup_done", 0, startup_done_r);
    cfg_tx(0, 1, 18'h0ff10, 2, `JSPU_PRIO_RESET, 8'h25);
    cfg_tx(1, 1, 18'h0ff10, 0, `JSPU_PRIO_RESET, 8'h25);
    cfg_tx(11, 0, 18'h0ff30, 1, 3'h6, 8'hff);
    cfg_sig(0, 0, `JSPU_SRC_RX_MSG, 1, 8, 0, 0, 32'ha, 2);
    cfg_sig(0, 1, 5'h04, 2, 4, 4, 0, 32'h0, 1);
    cfg_sig(0, 2, `JSPU_SRC_RX_TOUT, 1, 8, 5, 0, 32'h0, 1);
    cfg_sig(0, 3, 5'h12, 1, 8, 6, 0, 32'h0, 1);
    cfg_sig(1, 0, 5'h02, 3, 12, 1, 4, 32'h3, 1);
    cfg_sig(1, 1, `JSPU_SRC_NOT_USED, 1, 8, 6, 0, 32'h0, 1);
    d = {64{1'b1}};
    d[7:0] = (101 - 10) * 2;
    d[23:12] = 203 - 3;
    d[35:32] = 4'hf;
    repeat (3) tq.push_back({1'b1, `JSPU_PRIO_RESET, 18'h0ff10,
      `JSPU_ADDR_GLOBAL, d});
    wait_tx;
    check("startup_done", 1, startup_done_r);
    cfg_tx(0, 1, 18'h0ff10, 0, `JSPU_PRIO_RESET, 8'h25);
    cfg_tx(2, 0, 18'h0ef00, 3, 3'h3, 8'h25);
    repeat (2) tq.push_back({1'b0, 3'h3, 18'h0ef00, 8'h25, {64{1'b1}}});
    wait_tx;
    cfg_tx(2, 0, 18'h0ef00, 0, 3'h3, 8'h25);
    repeat (800) @(negedge ref_clk);
    // timeout of 5 ms stays far above the few-cycle frame spacing
    cfg_rx(0, 1, 18'h0ef00, 8'h33, 5, 16, 2, 3, 32'hffff_fffb,
           32'ha, 32'h3e8);
    cfg_rx(1, 0, 18'h0ff20, 8'h10, 0, 8, 0, 1, 32'h0, 32'h0, 32'hff);
    v = 32'h0;
    dig = 1'b0;
    for (k = 0; k < 12; k = k + 1) begin
      f = (k == 0) ? 400 : (k == 1 || k == 3) ? 100 : (k == 2) ? 2 :
          ($random(seed) & 16'h01ff);
      i = (k != 4);
      sa = (k == 5) ? 8'h34 : 8'h33;
      d = {$random(seed), $random(seed)};
      d[31:16] = f;
      i_jspu_can_net.send(i, 18'h0ef00, sa, d);
      if (k != 4 && k != 5) begin
        s = f * 3 - 5;
        if (s >= 1000)
          dig = 1'b1;
        else if (s <= 10)
          dig = 1'b0;
        v = (s < 10) ? 10 : (s > 1000) ? 1000 : s;
      end
      rq.push_back({dig, v});
      repeat (4) @(negedge ref_clk);
    end
    repeat (380) @(negedge ref_clk);
    check("rx_lost", 9'h0, rx_lost_r);
    repeat (240) @(negedge ref_clk);
    check("rx_lost", 9'h1, rx_lost_r);
    check("rx_slot2", 32'h0, rx_value_r[95:64]);
    stop_test;
  end
endmodule // jspu_top_test
